// [core/mds_defs.svh]
`ifndef MDS_DEFS_SVH
`define MDS_DEFS_SVH

// Special-function codes (octal 01, 02, 06, 33, 36)
`define MDS_SPECIAL_FUNCTION_FIELD_JDISP    6'h01
`define MDS_SPECIAL_FUNCTION_FIELD_AREAD    6'h02
`define MDS_SPECIAL_FUNCTION_FIELD_NEXT_INSTRUCTION_CONDITION   6'h06
`define MDS_SPECIAL_FUNCTION_FIELD_BDISP    6'h1B
`define MDS_SPECIAL_FUNCTION_FIELD_EAMODE   6'h1E

// Control-store addresses (octal 40, 45, 140, 160, 161, 175, 504)
`define MDS_AREAD_BASE    11'h020
`define MDS_ADDR_FETCH    11'h025
`define MDS_ADDR_NEXT     11'h060
`define MDS_ADDR_EA_BASE  11'h070
`define MDS_ADDR_EA_INDEX 11'h071
`define MDS_ADDR_STORE    11'h07D
`define MDS_ADDR_ADD      11'h144

// Address-mode bit positions within the mode dispatch
`define MDS_MODE_INDEX_BIT    0
`define MDS_MODE_INDIRECT_BIT 1

`endif

// [core/mds_pkg.sv]
package mds_pkg;

   typedef logic [10:0] mds_uaddr_t;

   typedef enum
   {
      MDS_KIND_PLAIN,
      MDS_KIND_JDISP,
      MDS_KIND_AREAD,
      MDS_KIND_BDISP,
      MDS_KIND_EAMODE,
      MDS_KIND_NEXT_INSTRUCTION_CONDITION
   } mds_kind_t;

endpackage

// [core/mds_sequencer.sv]
`timescale 1ns/1ns
`include "mds_defs.svh"

module mds_sequencer
#(
   parameter int OPC_W  = 9,
   parameter int DATA_W = 36,
   parameter int ADDR_W = 18
)
(
   input  wire logic                 CLK_I,
   input  wire logic                 RESET_I,
   input  wire logic                 CE_I,
   input  wire logic [10:0]          MW_JUMP_I,
   input  wire logic [5:0]           MW_SPECIAL_FUNCTION_FIELD_I,
   input  wire logic [OPC_W-1:0]     OPCODE_I,
   input  wire logic                 IR_INDIRECT_I,
   input  wire logic [3:0]           IR_INDEX_SEL_I,
   input  wire logic [ADDR_W-1:0]    IR_ADDR_I,
   input  wire logic [DATA_W-1:0]    XR_DATA_I,
   input  wire logic                 DRAM_WE_I,
   input  wire logic [OPC_W-1:0]     DRAM_WADDR_I,
   input  wire logic [3:0]           DRAM_WREAD_I,
   input  wire logic [3:0]           DRAM_WSTORE_I,
   input  wire logic [10:0]          DRAM_WJUMP_I,
   input  wire logic [DATA_W-1:0]    MEM_DATA_I,
   input  wire logic                 MEM_VALID_I,
   output logic      [10:0]          UPC_O,
   output logic      [DATA_W-1:0]    AR_O,
   output logic      [DATA_W-1:0]    ACC0_O,
   output logic                      PREFETCH_O,
   output logic                      NEXT_INSTR_O
);

   localparam int DEPTH = 1 << OPC_W;

   function automatic mds_pkg::mds_kind_t decode_special_function_field(input logic [5:0] special_function_field);
      mds_pkg::mds_kind_t k;
      k = mds_pkg::MDS_KIND_PLAIN;
      unique case (special_function_field)
         `MDS_SPECIAL_FUNCTION_FIELD_JDISP:  k = mds_pkg::MDS_KIND_JDISP;
         `MDS_SPECIAL_FUNCTION_FIELD_AREAD:  k = mds_pkg::MDS_KIND_AREAD;
         `MDS_SPECIAL_FUNCTION_FIELD_BDISP:  k = mds_pkg::MDS_KIND_BDISP;
         `MDS_SPECIAL_FUNCTION_FIELD_EAMODE: k = mds_pkg::MDS_KIND_EAMODE;
         `MDS_SPECIAL_FUNCTION_FIELD_NEXT_INSTRUCTION_CONDITION: k = mds_pkg::MDS_KIND_NEXT_INSTRUCTION_CONDITION;
         default:          k = mds_pkg::MDS_KIND_PLAIN;
      endcase
      return k;
   endfunction

   logic [3:0]          dram_read  [DEPTH];
   logic [3:0]          dram_store [DEPTH];
   mds_pkg::mds_uaddr_t dram_jump  [DEPTH];

   mds_pkg::mds_uaddr_t upc;
   mds_pkg::mds_uaddr_t next_upc;
   mds_pkg::mds_uaddr_t jump_used;
   mds_pkg::mds_kind_t  kind;
   logic [DATA_W-1:0]   ar;
   logic [DATA_W-1:0]   acc0;
   logic                ea_pending;
   logic                indexed;
   logic                fetch_stall;
   logic                prefetch;
   logic                next_instr;

   assign kind        = decode_special_function_field(MW_SPECIAL_FUNCTION_FIELD_I);
   assign indexed     = |IR_INDEX_SEL_I;
   assign fetch_stall = (upc == `MDS_ADDR_FETCH) && !MEM_VALID_I;
   assign jump_used   = ea_pending ? `MDS_AREAD_BASE : MW_JUMP_I;

   // Dispatch memory, one word per opcode
   always_ff @(posedge CLK_I)
   begin
      if (CE_I && DRAM_WE_I)
      begin
         dram_read[DRAM_WADDR_I]  <= DRAM_WREAD_I;
         dram_store[DRAM_WADDR_I] <= DRAM_WSTORE_I;
         dram_jump[DRAM_WADDR_I]  <= DRAM_WJUMP_I;
      end
   end

   // Next control-store address
   always_comb
   begin
      next_upc = MW_JUMP_I;
      unique case (kind)
         mds_pkg::MDS_KIND_AREAD:
            next_upc = {7'h00, dram_read[OPCODE_I]} | `MDS_AREAD_BASE | jump_used;
         mds_pkg::MDS_KIND_JDISP:
            next_upc = dram_jump[OPCODE_I];
         mds_pkg::MDS_KIND_BDISP:
            next_upc = {7'h00, dram_store[OPCODE_I]} | MW_JUMP_I;
         mds_pkg::MDS_KIND_EAMODE:
            next_upc = MW_JUMP_I | {9'h000, IR_INDIRECT_I, indexed};
         mds_pkg::MDS_KIND_NEXT_INSTRUCTION_CONDITION:
            next_upc = MW_JUMP_I;
         mds_pkg::MDS_KIND_PLAIN:
            next_upc = MW_JUMP_I;
      endcase
      if (fetch_stall)
      begin
         next_upc = upc;
      end
   end

   // Microprogram counter; reset enters the next-instruction decision
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         upc <= `MDS_ADDR_NEXT;
      end
      else if (CE_I)
      begin
         upc <= next_upc;
      end
   end

   // Effective-address compute pending until the operand-read dispatch
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         ea_pending <= 1'b0;
      end
      else if (CE_I && !fetch_stall)
      begin
         if (kind == mds_pkg::MDS_KIND_EAMODE)
         begin
            ea_pending <= 1'b1;
         end
         else if (kind == mds_pkg::MDS_KIND_AREAD)
         begin
            ea_pending <= 1'b0;
         end
      end
   end

   // Arithmetic register: address field, indexing, operand, add
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         ar <= '0;
      end
      else if (CE_I && !fetch_stall)
      begin
         if (kind == mds_pkg::MDS_KIND_EAMODE)
         begin
            ar <= DATA_W'(IR_ADDR_I);
         end
         else if (upc == `MDS_ADDR_EA_INDEX)
         begin
            ar <= ar + XR_DATA_I;
         end
         else if (upc == `MDS_ADDR_FETCH && MEM_VALID_I)
         begin
            ar <= MEM_DATA_I;
         end
         else if (upc == `MDS_ADDR_ADD)
         begin
            ar <= ar + acc0;
         end
      end
   end

   // Accumulator zero written by the store step
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         acc0 <= '0;
      end
      else if (CE_I && upc == `MDS_ADDR_STORE)
      begin
         acc0 <= ar;
      end
   end

   // Prefetch and next-instruction pulses
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         prefetch   <= 1'b0;
         next_instr <= 1'b0;
      end
      else if (CE_I)
      begin
         prefetch   <= (upc == `MDS_ADDR_FETCH) && MEM_VALID_I;
         next_instr <= (kind == mds_pkg::MDS_KIND_NEXT_INSTRUCTION_CONDITION);
      end
   end

   assign UPC_O        = upc;
   assign AR_O         = ar;
   assign ACC0_O       = acc0;
   assign PREFETCH_O   = prefetch;
   assign NEXT_INSTR_O = next_instr;

   a_aread_dispatch: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && kind == mds_pkg::MDS_KIND_AREAD && !ea_pending && !fetch_stall
      |=> upc == ({7'h00, dram_read[$past(OPCODE_I)]} | 11'h020 | $past(MW_JUMP_I)))
      else $error("Operand-read dispatch address wrong");

   a_ea_forced_jump: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && kind == mds_pkg::MDS_KIND_EAMODE ##1
      CE_I && kind == mds_pkg::MDS_KIND_AREAD && !fetch_stall
      |=> upc == ({7'h00, dram_read[$past(OPCODE_I)]} | 11'h020))
      else $error("Jump field not forced after address compute");

   a_jdisp_only: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && kind == mds_pkg::MDS_KIND_JDISP && !fetch_stall
      |=> upc == dram_jump[$past(OPCODE_I)])
      else $error("Jump dispatch did not use dispatch word jump");

   a_bdisp_or: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && kind == mds_pkg::MDS_KIND_BDISP && !fetch_stall
      |=> upc == ({7'h00, dram_store[$past(OPCODE_I)]} | $past(MW_JUMP_I)))
      else $error("Store dispatch address wrong");

   a_next_instruction_condition_return: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && kind == mds_pkg::MDS_KIND_NEXT_INSTRUCTION_CONDITION && MW_JUMP_I == 11'h060 && !fetch_stall
      |=> NEXT_INSTR_O && upc == 11'h060)
      else $error("Next-instruction dispatch did not return to 140");

   a_fetch_stall: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && upc == 11'h025 && !MEM_VALID_I |=> upc == 11'h025 && !PREFETCH_O)
      else $error("Fetch step left before operand arrived");

   a_fetch_prefetch: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && upc == 11'h025 && MEM_VALID_I |=> PREFETCH_O && AR_O == $past(MEM_DATA_I))
      else $error("Operand not taken or prefetch not started");

   a_index_select: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && kind == mds_pkg::MDS_KIND_EAMODE && MW_JUMP_I == 11'h070
      && indexed && !IR_INDIRECT_I && !fetch_stall |=> upc == 11'h071)
      else $error("Indexed mode did not select 161");

   a_mode_paths: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && kind == mds_pkg::MDS_KIND_EAMODE && !fetch_stall
      |=> upc[1:0] == ($past(MW_JUMP_I[1:0]) | {$past(IR_INDIRECT_I), $past(indexed)}))
      else $error("Mode dispatch path bits wrong");

   a_index_sum: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && upc == 11'h071 && kind != mds_pkg::MDS_KIND_EAMODE
      |=> AR_O == $past(AR_O) + $past(XR_DATA_I))
      else $error("Indexed effective address wrong");

   a_store_acc: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && upc == 11'h07D |=> ACC0_O == $past(AR_O))
      else $error("Store step did not write accumulator zero");

   // Read bit, address load, add step, plain jump, pulse shapes, freezing and reset state
   a_read_bit: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && MW_SPECIAL_FUNCTION_FIELD_I == 6'h02 && !fetch_stall |=> UPC_O[5])
      else $error("Operand-read dispatch did not set the 40 bit");

   a_mode_load: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && kind == mds_pkg::MDS_KIND_EAMODE && !fetch_stall |=> AR_O == DATA_W'($past(IR_ADDR_I)))
      else $error("Address field not loaded on mode dispatch");

   a_add_step: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && upc == 11'h144 && kind != mds_pkg::MDS_KIND_EAMODE |=> AR_O == $past(AR_O) + $past(ACC0_O))
      else $error("Add step sum wrong");

   a_plain_jump: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && kind == mds_pkg::MDS_KIND_PLAIN && !fetch_stall |=> UPC_O == $past(MW_JUMP_I))
      else $error("Plain step did not take the jump field");

   a_prefetch_pulse: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && !(upc == 11'h025 && MEM_VALID_I) |=> !PREFETCH_O)
      else $error("Prefetch pulse without operand taken");

   a_instr_pulse: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && kind != mds_pkg::MDS_KIND_NEXT_INSTRUCTION_CONDITION |=> !NEXT_INSTR_O)
      else $error("Next-instruction pulse without code 06");

   a_ce_freeze: assert property (@(posedge CLK_I) disable iff (RESET_I)
      !CE_I |=> $stable(UPC_O) && $stable(AR_O) && $stable(ACC0_O)
      && $stable(PREFETCH_O) && $stable(NEXT_INSTR_O))
      else $error("State moved while clock enable low");

   a_reset_values: assert property (@(posedge CLK_I)
      RESET_I |=> UPC_O == 11'h060 && AR_O == '0 && ACC0_O == '0
      && !PREFETCH_O && !NEXT_INSTR_O)
      else $error("Reset state wrong");

endmodule

// [testbench/mds_mem_model.sv]
`timescale 1ns/1ns
module mds_mem_model
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic [10:0] upc_i,
   output logic             mem_valid_o,
   output logic [35:0]      mem_data_o
);
   logic [35:0] lfsr;
   logic [1:0]  wait_cnt;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lfsr <= 36'h5A5A5A5A5;
         wait_cnt <= 2'h0;
      end
      else if (ce_i)
      begin
         lfsr <= {lfsr[34:0], lfsr[35] ^ lfsr[24]};
         if (upc_i != 11'h025)
            wait_cnt <= lfsr[1:0];
         else if (wait_cnt != 2'h0)
            wait_cnt <= wait_cnt - 2'h1;
      end
   end
   // Data changes every clock-enabled cycle while not valid
   assign mem_valid_o = (upc_i == 11'h025) && (wait_cnt == 2'h0);
   assign mem_data_o  = mem_valid_o ? lfsr : ~lfsr;
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ns
`include "mds_defs.svh"
module testbench;
   logic        clk, rst, ce, we, ind, mval, pf, ni, flag, epf, eni;
   logic [10:0] jump, wj, upc, eu;
   logic [5:0]  special_function_field;
   logic [8:0]  opc, wa;
   logic [3:0]  xsel, wrf, ws;
   logic [17:0] ia;
   logic [35:0] xr, md, ar, acc, d, d0;
   logic [18:0] dm [512];
   logic [31:0] seed;
   logic [5:0]  codes [8];
   int          error_cnt = 0;
   int          n_checks = 0;
   int          cyc = 0;
   mds_sequencer dut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .MW_JUMP_I(jump),
      .MW_SPECIAL_FUNCTION_FIELD_I(special_function_field), .OPCODE_I(opc), .IR_INDIRECT_I(ind), .IR_INDEX_SEL_I(xsel),
      .IR_ADDR_I(ia), .XR_DATA_I(xr), .DRAM_WE_I(we), .DRAM_WADDR_I(wa),
      .DRAM_WREAD_I(wrf), .DRAM_WSTORE_I(ws), .DRAM_WJUMP_I(wj), .MEM_DATA_I(md),
      .MEM_VALID_I(mval), .UPC_O(upc), .AR_O(ar), .ACC0_O(acc), .PREFETCH_O(pf),
      .NEXT_INSTR_O(ni));
   mds_mem_model mem (.clk_i(clk), .rst_i(rst), .ce_i(ce), .upc_i(upc),
      .mem_valid_o(mval), .mem_data_o(md));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   function automatic logic [10:0] nxt(input logic [5:0] s, input logic [10:0] j);
      case (s)
         `MDS_SPECIAL_FUNCTION_FIELD_AREAD:  return {7'h0, dm[opc][18:15]} | `MDS_AREAD_BASE | (flag ? 11'h0 : j);
         `MDS_SPECIAL_FUNCTION_FIELD_JDISP:  return dm[opc][10:0];
         `MDS_SPECIAL_FUNCTION_FIELD_BDISP:  return {7'h0, dm[opc][14:11]} | j;
         `MDS_SPECIAL_FUNCTION_FIELD_EAMODE: return j | {9'h0, ind, xsel != 4'h0};
         default:          return j;
      endcase
   endfunction
   task automatic end_sim();
      if (error_cnt == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [18:0] w);
      we = 1'b1;
      wa = a;
      {wrf, ws, wj} = w;
      dm[a] = w;
      @(negedge clk);
   endtask
   task automatic step(input logic [5:0] s, input logic [10:0] j);
      special_function_field = s;
      jump = j;
      epf = ce ? (upc == `MDS_ADDR_FETCH) && mval : pf;
      eni = ce ? (s == `MDS_SPECIAL_FUNCTION_FIELD_NEXT_INSTRUCTION_CONDITION) : ni;
      eu = (!ce || (upc == `MDS_ADDR_FETCH && !mval)) ? upc : nxt(s, j);
      if (ce && !(upc == `MDS_ADDR_FETCH && !mval))
         flag = (s == `MDS_SPECIAL_FUNCTION_FIELD_EAMODE) || (flag && s != `MDS_SPECIAL_FUNCTION_FIELD_AREAD);
      @(negedge clk);
      chk("upc", eu, upc);
      chk("prefetch", epf, pf);
      chk("next_instr", eni, ni);
   endtask
   task automatic fetch();
      while (!mval)
         step(`MDS_SPECIAL_FUNCTION_FIELD_JDISP, 11'h0);
      d = md;
      step(`MDS_SPECIAL_FUNCTION_FIELD_JDISP, 11'h0);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         error_cnt++;
         end_sim();
      end
   end
   initial
   begin
      seed = 32'h0000CD2E;
      codes = '{6'h01, 6'h02, 6'h06, 6'h1B, 6'h1E, 6'h10, 6'h2A, 6'h3F};
      {rst, ce, we, ind, flag} = 5'h18;
      special_function_field = 6'h10;
      jump = `MDS_ADDR_NEXT;
      {opc, xsel, ia, xr, wa, wrf, ws, wj} = '0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("upc_rst", `MDS_ADDR_NEXT, upc);
      wr(9'h080, {4'h5, 4'h5, 11'h040});
      wr(9'h0B8, {4'h5, 4'h5, `MDS_ADDR_ADD});
      for (int i = 0; i < 16; i++)
      begin
         seed = xs(seed);
         wr(9'(i), seed[18:0]);
      end
      we = 1'b0;
      opc = 9'h080;
      ia = 18'h2AB5C;
      step(`MDS_SPECIAL_FUNCTION_FIELD_EAMODE, `MDS_ADDR_EA_BASE);
      chk("ar_ea", {18'h0, ia}, ar);
      step(`MDS_SPECIAL_FUNCTION_FIELD_AREAD, 11'h500);
      fetch();
      chk("ar_op", d, ar);
      step(`MDS_SPECIAL_FUNCTION_FIELD_BDISP, 11'h078);
      step(`MDS_SPECIAL_FUNCTION_FIELD_NEXT_INSTRUCTION_CONDITION, `MDS_ADDR_NEXT);
      chk("acc", d, acc);
      d0 = d;
      opc = 9'h0B8;
      xsel = 4'h3;
      xr = 36'h900000011;
      step(`MDS_SPECIAL_FUNCTION_FIELD_EAMODE, `MDS_ADDR_EA_BASE);
      step(`MDS_SPECIAL_FUNCTION_FIELD_AREAD, 11'h0);
      chk("ar_idx", {18'h0, ia} + xr, ar);
      fetch();
      step(`MDS_SPECIAL_FUNCTION_FIELD_BDISP, 11'h078);
      chk("ar_add", d + d0, ar);
      step(`MDS_SPECIAL_FUNCTION_FIELD_NEXT_INSTRUCTION_CONDITION, `MDS_ADDR_NEXT);
      chk("acc_add", d + d0, acc);
      for (int k = 0; k < 400; k++)
      begin
         seed = xs(seed);
         ce = seed[2:0] != 3'h0;
         opc = {5'h0, seed[6:3]};
         ind = seed[7];
         xsel = seed[11:8];
         ia = seed[29:12];
         xr = {4'h0, seed};
         step(upc == `MDS_ADDR_FETCH ? `MDS_SPECIAL_FUNCTION_FIELD_JDISP : codes[seed[14:12]], seed[31:21]);
      end
      ce = 1'b0;
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      ce = 1'b1;
      flag = 1'b0;
      chk("upc_rst2", `MDS_ADDR_NEXT, upc);
      chk("ar_rst", 36'h0, ar);
      chk("acc_rst", 36'h0, acc);
      chk("pf_rst", 36'h0, pf);
      chk("ni_rst", 36'h0, ni);
      step(`MDS_SPECIAL_FUNCTION_FIELD_AREAD, 11'h400);
      end_sim();
   end
endmodule
